// ### verilog/anpr_pkg.sv
// Package for the auto-negotiation next-page register slice: map, fields, resets, carriers
package anpr_pkg;

    // Management register addresses (5-bit register index)
    localparam logic [4:0] ANPR_ADDR_LP_BASE = 5'h05; // Partner base page, held here in lp_base_word_ff, reads 0
    localparam logic [4:0] ANPR_ADDR_EXP = 5'h06; // Expansion status
    localparam logic [4:0] ANPR_ADDR_NPTX = 5'h07; // Next-page transmit
    localparam logic [4:0] ANPR_ADDR_LPNP = 5'h08; // Partner next-page receive

    // Expansion status bit positions
    localparam int ANPR_EXP_BASE_PAGE = 5;
    localparam int ANPR_EXP_PD_FAULT = 4;
    localparam int ANPR_EXP_LP_NP_ABLE = 3;
    localparam int ANPR_EXP_NP_ABLE = 2;
    localparam int ANPR_EXP_PAGE_RX = 1;
    localparam int ANPR_EXP_LP_AN_ABLE = 0;
    localparam int ANPR_EXP_RSV_LO = 6;
    localparam int ANPR_EXP_RSV_HI = 15;

    // Page word layout, shared by transmit and receive registers
    localparam int ANPR_PG_MORE = 15;
    localparam int ANPR_PG_ACK = 14;
    localparam int ANPR_PG_FMT = 13;
    localparam int ANPR_PG_SECOND_ACKNOWLEDGE = 12;
    localparam int ANPR_PG_TOGGLE = 11;
    localparam int ANPR_PG_CODE_HI = 10;

    // Reset values
    localparam logic [15:0] ANPR_NPTX_RST = 16'h2001; // Formatted message, code field 1
    localparam logic [15:0] ANPR_NPTX_WMASK = 16'hBFFF; // Bit 14 reserved, reads 0
    localparam logic [15:0] ANPR_LP_RST = 16'h0000;
    localparam logic [15:0] ANPR_ZERO16 = 16'h0000;
    localparam logic ANPR_LOCAL_NP_ABLE_RST = 1'b1;

    // A page handed over by the negotiation engine
    typedef struct packed {
        logic valid;    // One-cycle pulse: a new page has arrived
        logic is_base;  // Base page when set, next page otherwise
        logic [15:0] word; // Received link code word
    } anpr_page_type;

    // Level status and the fault pulse from the negotiation engine
    typedef struct packed {
        logic page_received_variable; // Engine's page-received variable
        logic transmit_disable;       // Engine's transmit-disable condition
        logic parallel_fault;         // One-cycle pulse: parallel detection fault
        logic partner_np_able;        // Partner is next-page able
        logic partner_an_able;        // Partner is auto-negotiation able
    } anpr_link_type;

endpackage : anpr_pkg

// ### verilog/anpr_regs.sv
// Expansion, next-page transmit and partner next-page registers of the negotiation block
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Base-page flag 6.5, latching high, read-only
// - Parallel fault flag 6.4 latches, resets 0
// - Bit 6.3 shows partner next-page ability
// - Bit 6.2 shows local next-page ability, 1
// - Page-received 6.1 latches, cleared on read
// - Enabled: clear flag on engine conditions
// - Load received word and raise flag on the same edge
// - Bit 6.0 shows partner negotiation ability
// - Bit 7.15 more-pages-follow, writable, resets 0
// - Bit 7.13 formatted-message flag, resets 1
// - Bit 7.12 second acknowledge, resets 0
// - Bit 7.11 toggles each sent word, unless written in that cycle
// - Bit 8.15 partner has more pages
// - Bit 8.14 partner acknowledged our word
// - Bit 8.13 partner message flag, resets 0
// - Bit 8.12 partner complies with message
// - Bit 8.11 partner toggle value
// - Enable bit gates base-page flag capability
module anpr_regs
    import anpr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire anpr_page_type page_in,
    input wire anpr_link_type link_in,
    input wire logic alt_next_page_enable,
    input wire logic tx_page_sent,
    output logic [15:0] reg_rdata_ff,
    output logic [15:0] tx_word_ff,
    output logic [15:0] lp_base_word_ff,
    output logic page_received_ff
);

    // Latched and mirrored expansion status
    logic base_page_ff; // Base page received, latching
    logic pd_fault_ff; // Parallel detection fault, latching
    logic lp_np_able_ff; // Partner next-page ability mirror
    logic lp_an_able_ff; // Partner negotiation ability mirror
    logic local_np_able_ff; // Local next-page ability, constant after reset
    logic [15:0] lp_next_word_ff; // Partner next-page receive word
    logic checks_live_ff; // Low after any reset edge, keeps checks off there

    // Next values
    logic nxt_base_page;
    logic nxt_pd_fault;
    logic nxt_lp_np_able;
    logic nxt_lp_an_able;
    logic nxt_page_received;
    logic [15:0] nxt_tx_word;
    logic [15:0] nxt_lp_next_word;
    logic [15:0] nxt_lp_base_word;
    logic [15:0] nxt_rdata;

    // Decoded accesses
    logic rd_exp; // Software read of expansion status
    logic wr_nptx; // Software write of transmit page
    logic engine_clr; // Engine-side clear of page-received
    logic [15:0] exp_view; // Expansion register as read

    // Access decode and expansion read image
    always_comb
    begin
        rd_exp = reg_rd && (reg_addr == ANPR_ADDR_EXP);
        wr_nptx = reg_wr && (reg_addr == ANPR_ADDR_NPTX);
        // Engine clear only acts with the alternate feature on
        engine_clr = alt_next_page_enable
            && (!link_in.page_received_variable || link_in.transmit_disable);
        exp_view = ANPR_ZERO16; // Reserved upper bits stay 0
        exp_view[ANPR_EXP_BASE_PAGE] = base_page_ff;
        exp_view[ANPR_EXP_PD_FAULT] = pd_fault_ff;
        exp_view[ANPR_EXP_LP_NP_ABLE] = lp_np_able_ff;
        exp_view[ANPR_EXP_NP_ABLE] = local_np_able_ff;
        exp_view[ANPR_EXP_PAGE_RX] = page_received_ff;
        exp_view[ANPR_EXP_LP_AN_ABLE] = lp_an_able_ff;
    end

    // Status flags: a set in the same cycle as a clear wins, so no event is lost
    always_comb
    begin
        nxt_lp_np_able = link_in.partner_np_able;
        nxt_lp_an_able = link_in.partner_an_able;
        // Page received: set by a new page, cleared by read or engine
        if (page_in.valid)
        begin
            nxt_page_received = 1'b1;
        end
        else if (rd_exp || engine_clr)
        begin
            nxt_page_received = 1'b0;
        end
        else
        begin
            nxt_page_received = page_received_ff; // Hold until read or engine clear
        end
        // Base page only tracked while the alternate feature is enabled
        if (page_in.valid && page_in.is_base && alt_next_page_enable)
        begin
            nxt_base_page = 1'b1;
        end
        else if (rd_exp)
        begin
            nxt_base_page = 1'b0;
        end
        else
        begin
            nxt_base_page = base_page_ff;
        end
        // Parallel fault latches until read
        if (link_in.parallel_fault)
        begin
            nxt_pd_fault = 1'b1;
        end
        else if (rd_exp)
        begin
            nxt_pd_fault = 1'b0;
        end
        else
        begin
            nxt_pd_fault = pd_fault_ff;
        end
    end

    // Received words: loaded on the same edge that raises the flag
    always_comb
    begin
        nxt_lp_base_word = lp_base_word_ff;
        nxt_lp_next_word = lp_next_word_ff;
        if (page_in.valid && page_in.is_base)
        begin
            nxt_lp_base_word = page_in.word;
        end
        else if (page_in.valid)
        begin
            // Fields 15..11 carry partner NP, ACK, MP, SECOND_ACKNOWLEDGE, toggle
            nxt_lp_next_word = page_in.word;
        end
    end

    // Transmit page: software write wins over the hardware toggle flip
    always_comb
    begin
        nxt_tx_word = tx_word_ff;
        if (wr_nptx)
        begin
            // Reserved bit 14 is never stored
            nxt_tx_word = reg_wdata & ANPR_NPTX_WMASK;
        end
        else if (tx_page_sent)
        begin
            // Next word carries the inverse of the one just sent
            nxt_tx_word[ANPR_PG_TOGGLE] = ~tx_word_ff[ANPR_PG_TOGGLE];
        end
    end

    // Read data mux; reads of unmapped addresses return 0
    always_comb
    begin
        nxt_rdata = reg_rdata_ff; // Holds last read between accesses
        if (reg_rd)
        begin
            case (reg_addr)
                ANPR_ADDR_EXP: nxt_rdata = exp_view;
                ANPR_ADDR_NPTX: nxt_rdata = tx_word_ff;
                ANPR_ADDR_LPNP: nxt_rdata = lp_next_word_ff;
                default: nxt_rdata = ANPR_ZERO16;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            base_page_ff <= 1'b0;
            pd_fault_ff <= 1'b0;
            lp_np_able_ff <= 1'b0;
            lp_an_able_ff <= 1'b0;
            local_np_able_ff <= ANPR_LOCAL_NP_ABLE_RST;
            page_received_ff <= 1'b0;
            tx_word_ff <= ANPR_NPTX_RST;
            lp_next_word_ff <= ANPR_LP_RST;
            lp_base_word_ff <= ANPR_LP_RST;
            reg_rdata_ff <= ANPR_ZERO16;
            checks_live_ff <= 1'b0;
        end
        else
        begin
            base_page_ff <= nxt_base_page;
            pd_fault_ff <= nxt_pd_fault;
            lp_np_able_ff <= nxt_lp_np_able;
            lp_an_able_ff <= nxt_lp_an_able;
            local_np_able_ff <= local_np_able_ff;
            page_received_ff <= nxt_page_received;
            tx_word_ff <= nxt_tx_word;
            lp_next_word_ff <= nxt_lp_next_word;
            lp_base_word_ff <= nxt_lp_base_word;
            reg_rdata_ff <= nxt_rdata;
            checks_live_ff <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    // A reset released on an edge still resets the logic on that edge; the live flag
    // keeps the checks off there too, so no check judges state that reset just cleared
    default disable iff (srst || !checks_live_ff);

    base_gate_a: assert property (
        (!alt_next_page_enable && !base_page_ff) |=> !base_page_ff)
        else $error("base page flag set while feature disabled");

    base_latch_a: assert property (
        (page_in.valid && page_in.is_base && alt_next_page_enable) |=> base_page_ff)
        else $error("base page flag not set by base page");

    pd_latch_a: assert property (
        link_in.parallel_fault ##1 !rd_exp |=> pd_fault_ff)
        else $error("parallel fault flag lost before read");

    partner_mirror_a: assert property (
        ##1 (lp_np_able_ff == $past(link_in.partner_np_able))
            && (lp_an_able_ff == $past(link_in.partner_an_able)))
        else $error("partner ability mirror wrong");

    exp_read_a: assert property (
        (reg_rd && reg_addr == ANPR_ADDR_EXP) |=>
            reg_rdata_ff[ANPR_EXP_RSV_HI:ANPR_EXP_RSV_LO] == 10'h000
            && reg_rdata_ff[ANPR_EXP_NP_ABLE])
        else $error("expansion read image wrong");

    rd_clear_a: assert property (
        (rd_exp && !page_in.valid) |=> !page_received_ff)
        else $error("page received not cleared by read");

    engine_clear_a: assert property (
        (engine_clr && !page_in.valid) |=> !page_received_ff)
        else $error("page received not cleared by engine");

    load_flag_a: assert property (
        (page_in.valid && !page_in.is_base) |=>
            page_received_ff && lp_next_word_ff == $past(page_in.word))
        else $error("next page not loaded with flag");

    hold_flag_a: assert property (
        (page_received_ff && !rd_exp && !engine_clr) |=> page_received_ff)
        else $error("page received dropped without read");

    toggle_flip_a: assert property (
        (tx_page_sent && !wr_nptx) |=>
            tx_word_ff[ANPR_PG_TOGGLE] != $past(tx_word_ff[ANPR_PG_TOGGLE]))
        else $error("toggle bit did not invert after send");

    tx_write_a: assert property (
        wr_nptx |=> tx_word_ff == ($past(reg_wdata) & ANPR_NPTX_WMASK)
            && !tx_word_ff[ANPR_PG_ACK])
        else $error("transmit page write not stored");

    // Fault flag setting, read images, word loading and holding
    pd_set_a: assert property (
        link_in.parallel_fault |=> pd_fault_ff)
        else $error("parallel fault flag not set");

    base_word_load_a: assert property (
        (page_in.valid && page_in.is_base) |=>
            lp_base_word_ff == $past(page_in.word) && page_received_ff)
        else $error("base page not loaded with flag");

    lp_word_hold_a: assert property (
        !(page_in.valid && !page_in.is_base) |=> lp_next_word_ff == $past(lp_next_word_ff))
        else $error("partner next page changed without a page");

    lpnp_read_a: assert property (
        (reg_rd && reg_addr == ANPR_ADDR_LPNP) |=>
            reg_rdata_ff == $past(lp_next_word_ff))
        else $error("partner next page read image wrong");

    tx_read_a: assert property (
        (reg_rd && reg_addr == ANPR_ADDR_NPTX) |=>
            reg_rdata_ff == $past(tx_word_ff) && !reg_rdata_ff[ANPR_PG_ACK])
        else $error("transmit page read image wrong");

    read_hold_a: assert property (
        !reg_rd |=> reg_rdata_ff == $past(reg_rdata_ff))
        else $error("read data changed without a read");

endmodule : anpr_regs

`default_nettype wire

// ### bench/anpr_link_partner.sv
// Remote link partner model: turns bench commands into received pages and link status
`timescale 1ns/1ps
`default_nettype none

module anpr_link_partner
    import anpr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic send_page,
    input wire logic send_base,
    input wire logic [15:0] send_word,
    input wire logic pd_fault,
    input wire logic [3:0] levels,
    output var anpr_page_type page_out,
    output var anpr_link_type link_out
);

    // One registered stage, like a real receiver handing over a decoded word
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            page_out <= '0;
            link_out <= '0;
        end
        else
        begin
            page_out.valid <= send_page;
            page_out.is_base <= send_base;
            // Idle word is scrambled so a design that samples off the pulse is caught
            page_out.word <= send_page ? send_word : ~page_out.word;
            // Levels order: variable, transmit disable, then partner abilities
            link_out <= '{levels[3], levels[2], pd_fault, levels[1], levels[0]};
        end
    end

endmodule : anpr_link_partner

`default_nettype wire

// ### bench/tb_autoneg_next_page_regs.sv
// Self-checking bench for the negotiation next-page register slice
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_autoneg_next_page_regs;
    import anpr_pkg::*;

    logic clk, srst, reg_wr, reg_rd, alt_next_page_enable, tx_page_sent; // Design controls
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_ff, tx_word_ff, lp_base_word_ff;
    logic page_received_ff;
    anpr_page_type page_in;
    anpr_link_type link_in;
    logic send_page, send_base, pd_fault; // Partner commands
    logic [15:0] send_word;
    logic [3:0] levels;
    int mismatches, checks_done, cyc, img; // Bookkeeping
    int m_tx, m_lp, m_lb, m_rd; // Model words
    bit m_bp, m_pf, m_pr, m_lnp, m_lan, armed; // Model status bits
    logic [31:0] seed;

    anpr_regs uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .page_in(page_in), .link_in(link_in),
        .alt_next_page_enable(alt_next_page_enable), .tx_page_sent(tx_page_sent),
        .reg_rdata_ff(reg_rdata_ff), .tx_word_ff(tx_word_ff),
        .lp_base_word_ff(lp_base_word_ff), .page_received_ff(page_received_ff));

    anpr_link_partner partner (.clk(clk), .srst(srst), .send_page(send_page),
        .send_base(send_base), .send_word(send_word), .pd_fault(pd_fault),
        .levels(levels), .page_out(page_in), .link_out(link_in));

    // Shift-register generator, cheap and repeatable
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Reference model: sees the same inputs as the design at each rising edge
    always @(posedge clk)
    begin
        if (srst)
        begin
            {m_bp, m_pf, m_pr, m_lnp, m_lan} = '0;
            m_tx = 16'h2001;
            m_lp = 0;
            m_lb = 0;
            m_rd = 0;
        end
        else
        begin
            img = {10'h000, m_bp, m_pf, m_lnp, 1'b1, m_pr, m_lan};
            if (reg_rd)
            begin
                m_rd = reg_addr == 6 ? img : reg_addr == 7 ? m_tx : reg_addr == 8 ? m_lp : 0;
                if (reg_addr == 6)
                    {m_bp, m_pf, m_pr} = '0;
            end
            // Clears first so that a set in the same cycle wins
            if (alt_next_page_enable && (!link_in.page_received_variable
                || link_in.transmit_disable))
                m_pr = 0;
            if (page_in.valid)
            begin
                if (page_in.is_base)
                    m_lb = page_in.word;
                else
                    m_lp = page_in.word;
                if (page_in.is_base && alt_next_page_enable)
                    m_bp = 1;
                m_pr = 1;
            end
            if (link_in.parallel_fault)
                m_pf = 1;
            m_lnp = link_in.partner_np_able;
            m_lan = link_in.partner_an_able;
            if (tx_page_sent)
                m_tx = m_tx ^ 16'h0800;
            if (reg_wr && reg_addr == 7)
                m_tx = reg_wdata & 16'hBFFF;
        end
    end

    // Every output compared each cycle, once the edges have settled
    always @(negedge clk)
    begin
        if (armed)
        begin
            `CHK("read data", m_rd[15:0], reg_rdata_ff)
            `CHK("tx word", m_tx[15:0], tx_word_ff)
            `CHK("base word", m_lb[15:0], lp_base_word_ff)
            `CHK("page flag", m_pr, page_received_ff)
        end
    end

    // Hang guard: the run needs about 3020 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // Reset, then random traffic with a second reset in mid-run
    initial
    begin
        {srst, reg_wr, reg_rd, alt_next_page_enable, tx_page_sent} = 5'h10;
        {send_page, send_base, pd_fault, reg_addr, reg_wdata, send_word, levels} = '0;
        {mismatches, checks_done, cyc} = '0;
        armed = 1'b0;
        seed = 32'h00000E1B;
        @(posedge clk);
        armed <= 1'b1;
        repeat (15) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge clk);
            seed = xs(seed);
            srst <= (i >= 1500 && i < 1502);
            reg_rd <= seed[1:0] == 2'h0;
            reg_wr <= seed[4:2] == 3'h0;
            reg_addr <= {2'h0, seed[7:5]} + 5'h03; // Mapped 6..8 plus unmapped 3..5, 9 and 10
            reg_wdata <= seed[31:16];
            send_page <= seed[10:8] == 3'h0;
            send_base <= seed[11];
            send_word <= seed[31:16] ^ seed[15:0];
            pd_fault <= seed[15:12] == 4'h0;
            levels <= {seed[18:16] != 3'h0, seed[21:19] == 3'h0, seed[22], seed[23]};
            alt_next_page_enable <= seed[25:24] != 2'h0;
            tx_page_sent <= seed[28:26] == 3'h0;
        end
        repeat (3) @(posedge clk);
        tally_and_finish();
    end

endmodule : tb_autoneg_next_page_regs

`default_nettype wire
